// ===== core/sbsf_pkg.sv
// Purpose: constants and types shared by the serial port baud and flag block
// Assumes: byte-wide register port, one bus clock of 20 MHz
// Notes: the list below is the behaviour contract of the block
//
// Contract
// - bit rate configuration is readable and writable at any time, even mid-transfer
// - prescale_select in bits 6:4 divides the bus clock by code plus one
// - prescaler runs on the bus clock and feeds the rate divider
// - rate_select in bits 2:0 divides by two to the power code plus one
// - rate divider output is the serial bit clock in master mode
// - port_flags unimplemented bits read zero; writes to it change nothing
// - receive_full_flag at bit 7 sets when a received byte is ready
// - receive_full_flag clears by status read seeing it set, then data read
// - transmit_empty_flag at bit 5 sets when a byte moves into the shifter
// - transmit_empty_flag clears by status read seeing it set, then data write
// - data write without prior status read seeing transmit_empty_flag is ignored
// - idle port passes a written byte on and sets transmit_empty_flag within two cycles
// - at shift end a queued byte moves in and sets the flag; otherwise nothing
// - interrupt requested while transmit_empty_flag and transmit_irq_enable are set
// - mode_fault_flag at bit 4 sets when master and slave select is driven low
// - slave select is a fault input only with master, fault enable, no select output
// - mode_fault_flag clears by status read seeing it, then first control write
// - clearing port_enable aborts, flushes, clears receive flag, sets transmit flag
// - interrupt requested while receive_irq_enable and receive or fault flag set
// - in master mode a data write into the transmit buffer starts a transfer
package sbsf_pkg;

   // register offsets
   localparam logic [2:0] OFS_FIRST_CONTROL = 3'h0;
   localparam logic [2:0] OFS_SECOND_CONTROL = 3'h1;
   localparam logic [2:0] OFS_BIT_RATE_CONFIG = 3'h2;
   localparam logic [2:0] OFS_PORT_FLAGS = 3'h3;
   localparam logic [2:0] OFS_DATA_BUFFER = 3'h5;

   // first control register fields
   localparam int CTL1_RECEIVE_IRQ_ENABLE = 7;
   localparam int CTL1_PORT_ENABLE = 6;
   localparam int CTL1_TRANSMIT_IRQ_ENABLE = 5;
   localparam int CTL1_MASTER_SELECT = 4;
   localparam int CTL1_SELECT_OUTPUT_ENABLE = 1;
   // second control register field
   localparam int CTL2_FAULT_FUNCTION_ENABLE = 4;
   // bit rate fields
   localparam int BR_PRESCALE_MSB = 6;
   localparam int BR_PRESCALE_LSB = 4;
   localparam int BR_RATE_MSB = 2;
   localparam int BR_RATE_LSB = 0;
   // status fields
   localparam int FLG_RECEIVE_FULL = 7;
   localparam int FLG_TRANSMIT_EMPTY = 5;
   localparam int FLG_MODE_FAULT = 4;

   // reset values
   localparam logic [7:0] RST_FIRST_CONTROL = 8'h00;
   localparam logic [7:0] RST_SECOND_CONTROL = 8'h00;
   localparam logic [7:0] RST_BIT_RATE_CONFIG = 8'h00;
   localparam logic [7:0] RST_DATA = 8'h00;
   // readable bit masks
   localparam logic [7:0] MASK_SECOND_CONTROL = 8'h10;
   localparam logic [7:0] MASK_BIT_RATE_CONFIG = 8'h77;

   // one byte is sixteen serial clock edges
   localparam logic [3:0] LAST_EDGE = 4'hf;
   localparam int SYNC_STAGES = 2;

   typedef enum logic [1:0] {
      SBSF_IDLE  = 2'b01,
      SBSF_SHIFT = 2'b10
   } sbsf_state_t;

endpackage

// ===== core/sbsf_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to CLK
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module sbsf_sync #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // pins and synchronised copies
   input  wire logic [WIDTH-1:0] pin_in,
   input  wire logic [WIDTH-1:0] rst_val,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_ff <= rst_val;
         sync_out <= rst_val;
      end else begin
         meta_ff <= pin_in;
         sync_out <= meta_ff;
      end
   end
endmodule
`default_nettype wire

// ===== core/sbsf_baud.sv
// Purpose: prescaler and power-of-two rate divider for the serial clock
// Assumes: restart is a one-cycle pulse at each idle transfer start, not at a chained one
// Notes: half_tick marks each serial clock edge, twice per bit
`timescale 1ns/1ps
`default_nettype none
module sbsf_baud (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // control
   input  wire logic       restart,
   input  wire logic [2:0] prescale_select,
   input  wire logic [2:0] rate_select,
   // edge strobe
   output logic            half_tick
);
   logic [2:0] pre_cnt_ff;
   logic [6:0] div_cnt_ff;
   wire        pre_tick;
   wire        div_end;

   // half of the rate divisor, minus one, as a count limit
   function automatic logic [6:0] half_limit(input logic [2:0] sel);
      half_limit = 7'((8'h01 << sel) - 8'h01);
   endfunction

   assign pre_tick = (pre_cnt_ff == prescale_select);
   assign div_end = (div_cnt_ff == half_limit(rate_select));
   assign half_tick = pre_tick && div_end && !restart;

   always_ff @(posedge clk) begin
      if (!rst_n || restart || pre_tick) begin
         pre_cnt_ff <= 3'h0;
      end else begin
         pre_cnt_ff <= pre_cnt_ff + 3'h1;
      end
   end

   // a shrinking rate while counting wraps cleanly through the >= test
   always_ff @(posedge clk) begin
      if (!rst_n || restart) begin
         div_cnt_ff <= 7'h00;
      end else if (pre_tick) begin
         div_cnt_ff <= (div_cnt_ff >= half_limit(rate_select)) ? 7'h00 : div_cnt_ff + 7'h01;
      end
   end
endmodule
`default_nettype wire

// ===== core/sbsf_top.sv
// Purpose: serial port bit rate generator, transmit path and status flags
// Assumes: byte register port with read data one cycle after the read strobe
// Notes: master transfers only, clock idles low, sample on leading edge, msb first
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sbsf_top
   import sbsf_pkg::*;
(
   // clock and reset
   input  wire logic       CLK,
   input  wire logic       RST_N,
   // register port
   input  wire logic [2:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   // serial link
   output logic            SCK_OUT,
   output logic            MOSI_OUT,
   input  wire logic       MISO_IN,
   input  wire logic       SS_N_IN,
   output logic            SS_N_OUT,
   output logic            SS_N_OE,
   // interrupt request
   output logic            IRQ
);
   import sbsf_pkg::*;

   // configuration
   logic [7:0]  ctl1_ff;
   logic [7:0]  ctl2_ff;
   logic [7:0]  bit_rate_config_ff;
   // flags and their arming from a status read
   logic        receive_full_flag_ff;
   logic        transmit_empty_flag_ff;
   logic        mode_fault_flag_ff;
   logic        rf_armed_ff;
   logic        te_armed_ff;
   logic        mf_armed_ff;
   // data path
   logic [7:0]  tx_buf_ff;
   logic        tx_buf_valid_ff;
   logic [7:0]  rx_buf_ff;
   logic [7:0]  shift_ff;
   logic        sample_ff;
   logic [3:0]  edge_cnt_ff;
   sbsf_state_t state_ff;
   sbsf_state_t nxt_state;
   // synchronised pins
   wire  [1:0]  pins_sync;
   wire         miso_s;
   wire         ss_n_s;
   wire         half_tick;

   // both pins cross in from outside the bus clock domain
   sbsf_sync #(
      .WIDTH (SYNC_STAGES)
   ) u_sync (
      .clk      (CLK),
      .rst_n    (RST_N),
      .pin_in   ({MISO_IN, SS_N_IN}),
      .rst_val  (2'h1),
      .sync_out (pins_sync)
   );
   assign miso_s = pins_sync[1];
   assign ss_n_s = pins_sync[0];

   // control fields
   wire receive_irq_enable = ctl1_ff[CTL1_RECEIVE_IRQ_ENABLE];
   wire port_enable = ctl1_ff[CTL1_PORT_ENABLE];
   wire transmit_irq_enable = ctl1_ff[CTL1_TRANSMIT_IRQ_ENABLE];
   wire master_select = ctl1_ff[CTL1_MASTER_SELECT];
   wire select_output_enable = ctl1_ff[CTL1_SELECT_OUTPUT_ENABLE];
   wire fault_function_enable = ctl2_ff[CTL2_FAULT_FUNCTION_ENABLE];

   // address decode
   wire sel_ctl1 = (ADDR == OFS_FIRST_CONTROL);
   wire sel_ctl2 = (ADDR == OFS_SECOND_CONTROL);
   wire sel_br = (ADDR == OFS_BIT_RATE_CONFIG);
   wire sel_flags = (ADDR == OFS_PORT_FLAGS);
   wire sel_data = (ADDR == OFS_DATA_BUFFER);

   wire wr_ctl1 = WR && sel_ctl1;
   wire wr_ctl2 = WR && sel_ctl2;
   wire wr_br = WR && sel_br;
   wire rd_flags = RD && sel_flags;
   wire rd_data = RD && sel_data;
   wire wr_data = WR && sel_data;

   // a data write lands only after the flag was seen set
   wire data_accept = wr_data && te_armed_ff && port_enable;
   wire active = port_enable && master_select;

   // edge_cnt_ff counts serial clock edges of the frame; even counts are
   // leading edges (sample), odd counts trailing edges (shift)
   // transfer sequencing
   wire shifting = (state_ff == SBSF_SHIFT);
   wire leading_edge = shifting && half_tick && !edge_cnt_ff[0];
   wire trailing_edge = shifting && half_tick && edge_cnt_ff[0];
   wire shift_done = trailing_edge && (edge_cnt_ff == LAST_EDGE);
   wire [7:0] rx_byte = {shift_ff[6:0], sample_ff};
   // buffer to shifter move: idle, or right at the end of a shift
   wire load_idle = active && !shifting && tx_buf_valid_ff;
   wire load_chain = active && shift_done && tx_buf_valid_ff;
   wire load_shifter = load_idle || load_chain;

   // a chained load keeps the divider running, so back-to-back frames
   // keep an even bit spacing; only an idle start restarts it
   // fault detection
   wire fault_input = master_select && fault_function_enable && !select_output_enable;
   wire fault_event = port_enable && fault_input && !ss_n_s;

   // reads have no side effect in the mux; the clearing sequences live
   // in the arming registers below
   // read mux
   wire [7:0] flags_view = {receive_full_flag_ff, 1'b0, transmit_empty_flag_ff,
                            mode_fault_flag_ff, 4'h0};
   wire [7:0] rd_mux =
      sel_ctl1  ? ctl1_ff :
      sel_ctl2  ? (ctl2_ff & MASK_SECOND_CONTROL) :
      sel_br    ? (bit_rate_config_ff & MASK_BIT_RATE_CONFIG) :
      sel_flags ? flags_view :
      sel_data  ? rx_buf_ff : 8'h00;

   // restart on an idle start so the first edge is a full half period away
   sbsf_baud u_baud (
      .clk             (CLK),
      .rst_n           (RST_N),
      .restart         (load_idle),
      .prescale_select (bit_rate_config_ff[BR_PRESCALE_MSB:BR_PRESCALE_LSB]),
      .rate_select     (bit_rate_config_ff[BR_RATE_MSB:BR_RATE_LSB]),
      .half_tick       (half_tick)
   );

   // control writes take effect at the edge that samples the strobe
   // configuration registers
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ctl1_ff <= RST_FIRST_CONTROL;
      end else if (wr_ctl1) begin
         ctl1_ff <= WDATA;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ctl2_ff <= RST_SECOND_CONTROL;
      end else if (wr_ctl2) begin
         ctl2_ff <= WDATA & MASK_SECOND_CONTROL;
      end
   end

   // no interlock with the shifter: a new rate applies at the next count wrap
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         bit_rate_config_ff <= RST_BIT_RATE_CONFIG;
      end else if (wr_br) begin
         bit_rate_config_ff <= WDATA & MASK_BIT_RATE_CONFIG;
      end
   end

   // status-read arming; the first access of the pair is remembered here
   always_ff @(posedge CLK) begin
      if (!RST_N || !port_enable) begin
         rf_armed_ff <= 1'b0;
         te_armed_ff <= 1'b0;
      end else begin
         if (rd_flags && receive_full_flag_ff) begin
            rf_armed_ff <= 1'b1;
         end else if (rd_data) begin
            rf_armed_ff <= 1'b0;
         end
         if (rd_flags && transmit_empty_flag_ff) begin
            te_armed_ff <= 1'b1;
         end else if (wr_data) begin
            te_armed_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         mf_armed_ff <= 1'b0;
      end else if (rd_flags && mode_fault_flag_ff) begin
         mf_armed_ff <= 1'b1;
      end else if (wr_ctl1) begin
         mf_armed_ff <= 1'b0;
      end
   end

   // receive flag: a completing byte wins over a clearing read
   always_ff @(posedge CLK) begin
      if (!RST_N || !port_enable) begin
         receive_full_flag_ff <= 1'b0;
      end else if (shift_done) begin
         receive_full_flag_ff <= 1'b1;
      end else if (rd_data && rf_armed_ff) begin
         receive_full_flag_ff <= 1'b0;
      end
   end

   // transmit flag: tracks room in the buffer
   always_ff @(posedge CLK) begin
      if (!RST_N || !port_enable) begin
         transmit_empty_flag_ff <= 1'b1;
      end else if (load_shifter) begin
         transmit_empty_flag_ff <= 1'b1;
      end else if (data_accept) begin
         transmit_empty_flag_ff <= 1'b0;
      end
   end

   // fault flag survives a port disable so software can still see it
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         mode_fault_flag_ff <= 1'b0;
      end else if (fault_event) begin
         mode_fault_flag_ff <= 1'b1;
      end else if (wr_ctl1 && mf_armed_ff) begin
         mode_fault_flag_ff <= 1'b0;
      end
   end

   // a flushed buffer drops its byte; a cut frame is never resumed
   // transmit buffer
   always_ff @(posedge CLK) begin
      if (!RST_N || !port_enable) begin
         tx_buf_valid_ff <= 1'b0;
         tx_buf_ff <= RST_DATA;
      end else if (data_accept) begin
         tx_buf_valid_ff <= 1'b1;
         tx_buf_ff <= WDATA;
      end else if (load_shifter) begin
         tx_buf_valid_ff <= 1'b0;
      end
   end

   // receive buffer: an unread byte is kept and the new one is lost
   always_ff @(posedge CLK) begin
      if (!RST_N || !port_enable) begin
         rx_buf_ff <= RST_DATA;
      end else if (shift_done && !receive_full_flag_ff) begin
         rx_buf_ff <= rx_byte;
      end
   end

   // no state for a cut frame: losing active returns the machine to idle
   // at the next edge and the counters follow
   // transfer state machine
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SBSF_IDLE: begin
            if (load_idle) begin
               nxt_state = SBSF_SHIFT;
            end
         end
         SBSF_SHIFT: begin
            if (shift_done && !load_chain) begin
               nxt_state = SBSF_IDLE;
            end
         end
         default: begin
            nxt_state = SBSF_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_N || !active) begin
         state_ff <= SBSF_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N || !active || load_shifter) begin
         edge_cnt_ff <= 4'h0;
      end else if (shifting && half_tick) begin
         edge_cnt_ff <= edge_cnt_ff + 4'h1;
      end
   end

   // transmit bits leave from the top while received bits fill in below
   // shifter: sample on leading edge, shift on trailing edge
   always_ff @(posedge CLK) begin
      if (!RST_N || !active) begin
         shift_ff <= RST_DATA;
         sample_ff <= 1'b0;
      end else if (load_shifter) begin
         shift_ff <= tx_buf_ff;
      end else if (leading_edge) begin
         sample_ff <= miso_s;
      end else if (trailing_edge) begin
         shift_ff <= rx_byte;
      end
   end

   // sck idles low; the last edge of a frame comes with the done pulse
   // serial pins
   always_ff @(posedge CLK) begin
      if (!RST_N || !active) begin
         SCK_OUT <= 1'b0;
         MOSI_OUT <= 1'b0;
      end else begin
         if (shifting && half_tick && !shift_done) begin
            SCK_OUT <= !SCK_OUT;
         end else if (shift_done || load_shifter) begin
            SCK_OUT <= 1'b0;
         end
         if (load_shifter) begin
            MOSI_OUT <= tx_buf_ff[7];
         end else if (trailing_edge) begin
            MOSI_OUT <= shift_ff[6];
         end
      end
   end

   // automatic select output in master mode when fault function and select output are both enabled
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         SS_N_OE <= 1'b0;
         SS_N_OUT <= 1'b1;
      end else begin
         SS_N_OE <= active && fault_function_enable && select_output_enable;
         SS_N_OUT <= !(nxt_state == SBSF_SHIFT && active);
      end
   end

   // the interrupt is registered, so it trails its flag or enable by a cycle
   // read data are zero outside the answer cycle so an or-ed bus stays clean
   // register read data and interrupt
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         RDATA <= 8'h00;
         IRQ <= 1'b0;
      end else begin
         RDATA <= RD ? rd_mux : 8'h00;
         IRQ <= (receive_irq_enable && (receive_full_flag_ff || mode_fault_flag_ff))
                || (transmit_irq_enable && transmit_empty_flag_ff);
      end
   end
endmodule
`default_nettype wire

// ===== test/sbsf_chk.sv
// Purpose: port assertions for the serial port rate and flag block
// Assumes: one bus clock, synchronous active-low reset
// Notes: bound to every sbsf_top instance below
`timescale 1ns/1ps
`default_nettype none
module sbsf_chk
   import sbsf_pkg::*;
(
   // clock and reset
   input  wire logic       CLK,
   input  wire logic       RST_N,
   // register port
   input  wire logic [2:0] ADDR,
   input  wire logic       RD,
   input  wire logic [7:0] RDATA,
   // serial link
   input  wire logic       SCK_OUT,
   input  wire logic       MOSI_OUT,
   input  wire logic       SS_N_OUT
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);

   logic        sck_ff;
   logic [10:0] gap_ff;
   wire         edge_seen = SCK_OUT != sck_ff;

   // cycles since the last serial clock edge inside a frame; saturates
   always_ff @(posedge CLK) begin
      sck_ff <= SCK_OUT;
      if (!RST_N || SS_N_OUT || edge_seen) begin
         gap_ff <= 11'h000;
      end else if (gap_ff != 11'h7ff) begin
         gap_ff <= gap_ff + 11'h001;
      end
   end

   status_zero_a: assert property (RD && ADDR == OFS_PORT_FLAGS |=> (RDATA & 8'h4f) == 8'h00)
      else $error("unimplemented status bits read non-zero");
   rate_zero_a: assert property (RD && ADDR == OFS_BIT_RATE_CONFIG |=> (RDATA & 8'h88) == 8'h00)
      else $error("unused bit rate bits read non-zero");
   unmapped_zero_a: assert property (RD && ADDR inside {3'h4, 3'h6, 3'h7} |=> RDATA == 8'h00)
      else $error("unmapped read returned data");
   rdata_idle_a: assert property (!RD |=> RDATA == 8'h00)
      else $error("read data present without a read");
   sck_idle_a: assert property (SS_N_OUT |-> !SCK_OUT)
      else $error("serial clock high outside a frame");
   sck_framed_a: assert property ($changed(SCK_OUT) |-> !$past(SS_N_OUT))
      else $error("serial clock moved while deselected");
   mosi_hold_a: assert property (SCK_OUT && $past(SCK_OUT) |-> $stable(MOSI_OUT))
      else $error("data out changed while clock high");
   edge_gap_a: assert property (gap_ff <= 11'd1030)
      else $error("serial clock half period too long");
endmodule

bind sbsf_top sbsf_chk u_sbsf_chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .RD(RD), .RDATA(RDATA),
   .SCK_OUT(SCK_OUT), .MOSI_OUT(MOSI_OUT), .SS_N_OUT(SS_N_OUT));
`default_nettype wire

// ===== test/sbsf_slave.sv
// Purpose: serial slave answering master frames, msb first
// Assumes: watches the master pins on the bus clock
// Notes: the data line wanders while deselected; answers lag one cycle
`timescale 1ns/1ps
`default_nettype none
module sbsf_slave (
   // clock
   input  wire logic       clk,
   // master pins
   input  wire logic       sck,
   input  wire logic       ss_n,
   input  wire logic       mosi,
   output logic            miso,
   // bench side
   input  wire logic [7:0] tx_byte,
   output logic      [7:0] rx_byte
);
   logic       sck_q = 1'b0;
   logic       ss_q = 1'b1;
   logic [7:0] sh;
   logic [7:0] rx;
   int         n;
   initial begin
      miso = 1'b0;
      rx_byte = 8'h00;
   end
   always @(posedge clk) begin
      if (ss_n) begin
         // no defined level when deselected
         miso <= ~miso;
         sh = tx_byte;
         n = 0;
      end else if (sck && !sck_q) begin
         rx = {rx[6:0], mosi};
         sh = {sh[6:0], 1'b0};
         n = n + 1;
         if (n == 8) begin
            rx_byte <= rx;
            sh = tx_byte;
            n = 0;
         end
      end else if (!sck && sck_q || ss_q) begin
         miso <= sh[7];
      end
      sck_q = sck;
      ss_q = ss_n;
   end
endmodule
`default_nettype wire

// ===== test/sbsf_top_test.sv
// Purpose: self-checking bench for the serial port rate and flag block
// Assumes: register reads answer one cycle after the strobe
// Notes: rx data is compared only at half periods of four or more cycles
`timescale 1ns/1ps
`default_nettype none
module sbsf_top_test;
   import sbsf_pkg::*;
   logic       clk;
   logic       rst_n;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic       wr_s;
   logic       rd_s;
   logic [7:0] rdata;
   logic       sck;
   logic       mosi;
   logic       miso;
   logic       ss_n_in;
   logic       ss_n_out;
   logic       ss_n_oe;
   logic       irq;
   logic [7:0] tx_b;
   logic [7:0] rx_b;
   logic [7:0] v;
   logic [7:0] b2;
   int         errors;
   int         total_checks;

   sbsf_top u_sbsf_top (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
      .RDATA(rdata), .SCK_OUT(sck), .MOSI_OUT(mosi), .MISO_IN(miso), .SS_N_IN(ss_n_in),
      .SS_N_OUT(ss_n_out), .SS_N_OE(ss_n_oe), .IRQ(irq));
   sbsf_slave u_sbsf_slave (.clk(clk), .sck(sck), .ss_n(ss_n_out), .mosi(mosi), .miso(miso),
      .tx_byte(tx_b), .rx_byte(rx_b));

   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic chk_reg(input logic [2:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      check(d, exp);
   endtask

   function automatic logic [7:0] exp_rst(input logic [2:0] a);
      return (a == OFS_PORT_FLAGS) ? 8'h20 : 8'h00;
   endfunction

   // one frame: edge spacing, bits on the wire, then flag and data handling
   task automatic xfer(input logic [2:0] p, input logic [2:0] r);
      int         half;
      int         n;
      int         k;
      logic       lst;
      logic [7:0] d;
      logic [7:0] got;
      half = (int'(p) + 1) << r;
      d = 8'($urandom);
      tx_b = 8'($urandom);
      wr(OFS_BIT_RATE_CONFIG, {1'b0, p, 1'b0, r});
      rd(OFS_PORT_FLAGS, v);
      wr(OFS_DATA_BUFFER, d);
      lst = 1'b0;
      n = 0;
      k = 0;
      got = 8'h00;
      while (k < 16 && n < 3000) begin
         @(posedge clk);
         #1;
         n++;
         if (sck !== lst) begin
            if (k > 0) check(16'(n), 16'(half));
            if (sck === 1'b1) got = {got[6:0], mosi};
            lst = sck;
            k++;
            n = 0;
         end
      end
      check(got, d);
      repeat (4) @(posedge clk);
      chk_reg(OFS_PORT_FLAGS, 8'ha0);
      rd(OFS_DATA_BUFFER, v);
      if (half >= 4) begin
         check(v, tx_b);
      end
      check(rx_b, d);
      chk_reg(OFS_PORT_FLAGS, 8'h20);
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      conclude();
   end

   initial begin
      rst_n = 1'b0;
      addr = 3'h0;
      wdata = 8'h00;
      wr_s = 1'b0;
      rd_s = 1'b0;
      ss_n_in = 1'b1;
      tx_b = 8'h00;
      errors = 0;
      total_checks = 0;
      v = 8'($urandom(32'hc821fa2b));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 8; a++) chk_reg(3'(a), exp_rst(3'(a)));
      wr(OFS_PORT_FLAGS, 8'hff);
      chk_reg(OFS_PORT_FLAGS, 8'h20);
      repeat (6) begin
         v = 8'($urandom);
         wr(OFS_BIT_RATE_CONFIG, v);
         chk_reg(OFS_BIT_RATE_CONFIG, v & 8'h77);
      end
      // a data write with no status read seen since enable is refused
      wr(OFS_DATA_BUFFER, 8'h00);
      wr(OFS_FIRST_CONTROL, 8'h70);
      wr(OFS_DATA_BUFFER, 8'h5a);
      repeat (8) @(posedge clk);
      check(ss_n_out, 1'b1);
      check(irq, 1'b1);
      wr(OFS_FIRST_CONTROL, 8'h50);
      repeat (2) @(posedge clk);
      check(irq, 1'b0);
      xfer(3'h0, 3'h0);
      xfer(3'h7, 3'h7);
      repeat (3) xfer(3'($urandom_range(7)), 3'($urandom_range(3)));
      // queued byte chains behind a running one; second received byte is lost
      wr(OFS_BIT_RATE_CONFIG, 8'h02);
      tx_b = 8'($urandom);
      b2 = 8'($urandom);
      rd(OFS_PORT_FLAGS, v);
      wr(OFS_DATA_BUFFER, 8'($urandom));
      chk_reg(OFS_PORT_FLAGS, 8'h20);
      wr(OFS_DATA_BUFFER, b2);
      chk_reg(OFS_PORT_FLAGS, 8'h00);
      repeat (200) @(posedge clk);
      check(rx_b, b2);
      rd(OFS_DATA_BUFFER, v);
      check(v, tx_b);
      chk_reg(OFS_PORT_FLAGS, 8'ha0);
      wr(OFS_FIRST_CONTROL, 8'hd0);
      repeat (2) @(posedge clk);
      check(irq, 1'b1);
      // abort a slow frame after a rate change in mid-flight
      wr(OFS_BIT_RATE_CONFIG, 8'h07);
      wr(OFS_DATA_BUFFER, 8'h3c);
      repeat (300) @(posedge clk);
      v = {1'b0, 3'($urandom), 4'h7};
      wr(OFS_BIT_RATE_CONFIG, v);
      chk_reg(OFS_BIT_RATE_CONFIG, v);
      check(ss_n_out, 1'b0);
      wr(OFS_FIRST_CONTROL, 8'h00);
      repeat (2) @(posedge clk);
      check({ss_n_out, sck}, 2'b10);
      chk_reg(OFS_PORT_FLAGS, 8'h20);
      // select pin as output: low level must not fault
      wr(OFS_SECOND_CONTROL, 8'h10);
      wr(OFS_FIRST_CONTROL, 8'hd2);
      ss_n_in <= 1'b0;
      repeat (6) @(posedge clk);
      check(ss_n_oe, 1'b1);
      ss_n_in <= 1'b1;
      chk_reg(OFS_PORT_FLAGS, 8'h20);
      wr(OFS_FIRST_CONTROL, 8'hd0);
      ss_n_in <= 1'b0;
      repeat (6) @(posedge clk);
      ss_n_in <= 1'b1;
      repeat (3) @(posedge clk);
      check({ss_n_oe, irq}, 2'b01);
      wr(OFS_FIRST_CONTROL, 8'hd0);
      chk_reg(OFS_PORT_FLAGS, 8'h30);
      wr(OFS_FIRST_CONTROL, 8'hd0);
      chk_reg(OFS_PORT_FLAGS, 8'h20);
      conclude();
   end
endmodule
`default_nettype wire
